// File: logic/scap_pkg.sv
package scap_pkg;
  // strap codes {hi, lo}
  localparam logic [1:0] MODE_EEPROM = 2'h0;
  localparam logic [1:0] MODE_SMBUS = 2'h1;
  // fixed command byte of every transaction
  localparam logic [7:0] CMD_CFG = 8'h08;
  // slave address bits 6:4
  localparam logic [2:0] ADDR_FIXED = 3'h6;
  // eeprom device address, plain default
  localparam logic [6:0] EE_DEV_ADDR = 7'h50;
  // eeprom start offset
  localparam logic [7:0] EE_START_OFS = 8'h00;
  // read answer when config data is late
  localparam logic [15:0] RD_FILL = 16'hffff;
  // link clock period and eeprom half bit time
  localparam int LINK_CLK_NS = 48;
  localparam int EE_HALF_NS = 5000;
  localparam int EE_HALF_CYC = (EE_HALF_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
  // set-up transaction order
  typedef enum logic [1:0] {SEQ_SETUP, SEQ_REG, SEQ_DATA} scap_seq_type;
endpackage : scap_pkg

// File: logic/scap_ee_if.sv
`timescale 1ns/1ps
interface scap_ee_if;
  logic run; // eeprom mode, out of reset
  logic scl; // clock drive level
  logic sda_o; // data drive level
  logic sda_oe; // data drive enable
  logic sda_i; // synchronised data pin
  logic word_valid; // word ready for config write
  logic word_ready; // config port free
  logic [15:0] word; // loaded word
  logic [15:0] word_addr; // byte offset of word
  modport master (input run, sda_i, word_ready,
    output scl, sda_o, sda_oe, word, word_addr, word_valid);
  modport ctrl (output run, sda_i, word_ready,
    input scl, sda_o, sda_oe, word, word_addr, word_valid);
endinterface : scap_ee_if

// File: logic/scap_ee_master.sv
`timescale 1ns/1ps
module scap_ee_master #(
  parameter int EE_BYTES = 256,
  parameter int HALF_CYC = scap_pkg::EE_HALF_CYC
) (
  input wire logic link_clk_i,
  input wire logic rst_i,
  scap_ee_if.master ee
);
  localparam int TW = $clog2(HALF_CYC + 1);
  typedef enum logic [3:0] {E_IDLE, E_START, E_WBIT, E_WACK, E_RBIT, E_RACK, E_HOLD, E_STOP, E_DONE} scap_est_type;
  scap_est_type st, next_st;
  logic [TW-1:0] tmr, next_tmr; // half bit timer
  logic [1:0] sub, next_sub; // phase inside a bit
  logic [2:0] bitn, next_bitn;
  logic [7:0] sh, next_sh;
  logic [1:0] wb, next_wb; // write byte index
  logic [15:0] rcnt, next_rcnt; // bytes read
  logic [7:0] lo, next_lo;
  logic scl, next_scl, sda_o, next_sda_o, sda_oe, next_sda_oe;
  logic wv, next_wv;
  logic [15:0] word, next_word, waddr, next_waddr;
  logic tick, last;
  // bytes sent before reading
  function automatic logic [7:0] wbyte(input logic [1:0] i);
    case (i)
      2'h0: wbyte = {scap_pkg::EE_DEV_ADDR, 1'b0};
      2'h1: wbyte = scap_pkg::EE_START_OFS;
      default: wbyte = {scap_pkg::EE_DEV_ADDR, 1'b1};
    endcase
  endfunction : wbyte
  assign tick = (tmr == '0);
  assign last = (rcnt == 16'(EE_BYTES - 1));
  assign ee.scl = scl;
  assign ee.sda_o = sda_o;
  assign ee.sda_oe = sda_oe;
  assign ee.word = word;
  assign ee.word_addr = waddr;
  assign ee.word_valid = wv;
  // bit sequencer: sub0 clock low and set data, sub1 clock high and sample
  always_comb begin
    next_st = st; next_sub = sub; next_bitn = bitn; next_sh = sh; next_wb = wb;
    next_rcnt = rcnt; next_lo = lo; next_scl = scl; next_sda_o = sda_o;
    next_sda_oe = sda_oe; next_wv = wv; next_word = word; next_waddr = waddr;
    next_tmr = tick ? TW'(HALF_CYC - 1) : tmr - 1'b1;
    if (st == E_HOLD) begin
      // stall the bus until the word is taken
      if (wv && ee.word_ready) begin
        next_wv = 1'b0;
        next_sub = 2'h0;
        next_st = (rcnt == 16'(EE_BYTES)) ? E_STOP : E_RBIT;
      end
    end else if (tick) begin
      case (st)
        E_IDLE: if (ee.run) begin
          next_st = E_START; next_sub = 2'h0; next_wb = 2'h0;
        end
        E_START: begin // also serves as repeated start
          next_sub = sub + 1'b1;
          case (sub)
            2'h0: begin next_scl = 1'b0; next_sda_o = 1'b1; next_sda_oe = 1'b1; end
            2'h1: next_scl = 1'b1;
            default: begin
              next_sda_o = 1'b0; next_sub = 2'h0; next_bitn = 3'h0;
              next_sh = wbyte(wb); next_st = E_WBIT;
            end
          endcase
        end
        E_WBIT: begin // data driven while sending
          next_sub = ~sub[0] ? 2'h1 : 2'h0;
          if (!sub[0]) begin
            next_scl = 1'b0; next_sda_oe = 1'b1; next_sda_o = sh[7];
          end else begin
            next_scl = 1'b1; next_sh = {sh[6:0], 1'b0}; next_bitn = bitn + 1'b1;
            if (bitn == 3'h7) next_st = E_WACK;
          end
        end
        E_WACK: begin // released while receiving
          next_sub = ~sub[0] ? 2'h1 : 2'h0;
          if (!sub[0]) begin
            next_scl = 1'b0; next_sda_oe = 1'b0;
          end else begin
            next_scl = 1'b1; next_sub = 2'h0;
            if (ee.sda_i) next_st = E_STOP; // no memory answers
            else if (wb == 2'h1) begin next_wb = 2'h2; next_st = E_START; end
            else if (wb == 2'h0) begin
              next_wb = 2'h1; next_sh = wbyte(2'h1); next_st = E_WBIT;
            end else begin next_bitn = 3'h0; next_st = E_RBIT; end
          end
        end
        E_RBIT: begin
          next_sub = ~sub[0] ? 2'h1 : 2'h0;
          if (!sub[0]) begin
            next_scl = 1'b0; next_sda_oe = 1'b0;
          end else begin
            next_scl = 1'b1; next_sh = {sh[6:0], ee.sda_i}; next_bitn = bitn + 1'b1;
            if (bitn == 3'h7) next_st = E_RACK;
          end
        end
        E_RACK: begin // acknowledge all but the last byte
          next_sub = ~sub[0] ? 2'h1 : 2'h0;
          if (!sub[0]) begin
            next_scl = 1'b0; next_sda_oe = 1'b1; next_sda_o = last;
          end else begin
            next_scl = 1'b1; next_rcnt = rcnt + 1'b1; next_bitn = 3'h0;
            if (!rcnt[0]) begin
              next_lo = sh; next_st = last ? E_STOP : E_RBIT;
            end else begin
              next_word = {sh, lo}; next_waddr = {rcnt[15:1], 1'b0};
              next_wv = 1'b1; next_st = E_HOLD;
            end
          end
        end
        E_STOP: begin
          next_sub = sub + 1'b1;
          case (sub)
            2'h0: begin next_scl = 1'b0; next_sda_o = 1'b0; next_sda_oe = 1'b1; end
            2'h1: next_scl = 1'b1;
            default: begin next_sda_o = 1'b1; next_st = E_DONE; end
          endcase
        end
        E_DONE: next_st = E_DONE;
        default: next_st = E_IDLE;
      endcase
    end
  end
  // sequencer registers
  always_ff @(posedge link_clk_i) begin
    if (rst_i) begin
      st <= E_IDLE; tmr <= '0; sub <= 2'h0; bitn <= 3'h0; sh <= 8'h00; wb <= 2'h0;
      rcnt <= 16'h0000; lo <= 8'h00; scl <= 1'b1; sda_o <= 1'b1; sda_oe <= 1'b0;
      wv <= 1'b0; word <= 16'h0000; waddr <= 16'h0000;
    end else begin
      st <= next_st; tmr <= next_tmr; sub <= next_sub; bitn <= next_bitn; sh <= next_sh;
      wb <= next_wb; rcnt <= next_rcnt; lo <= next_lo; scl <= next_scl;
      sda_o <= next_sda_o; sda_oe <= next_sda_oe; wv <= next_wv;
      word <= next_word; waddr <= next_waddr;
    end
  end
endmodule : scap_ee_master

// File: logic/scap_top.sv
// Functional notes
// - both straps low: eeprom master mode
// - hi strap low, lo high: smbus slave
// - eeprom mode drives the clock pin
// - eeprom mode data pin drives and samples
// - smbus mode clock pin input only
// - smbus mode data pin open drain
// - write: three transactions, command 08
// - sixteen bit values low byte first
// - read: command, repeated start, read address
// - read returns low byte then high byte
// - direction bit: zero write, one read
// - answer only own strapped address
// - smbus mode: pins strap address bits
// - address is 110 then four strap pins
`timescale 1ns/1ps
module scap_top #(
  parameter int EE_BYTES = 256,
  parameter int EE_HALF_CYC = scap_pkg::EE_HALF_CYC
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic link_clk_i,
  input wire logic iface_select_strap_hi_i,
  input wire logic iface_select_strap_lo_i,
  input wire logic [3:0] addr_strap_i,
  input wire logic mgmt_clock_pin_i,
  output logic mgmt_clock_pin_o,
  output logic mgmt_clock_pin_oe_o,
  input wire logic mgmt_data_pin_i,
  output logic mgmt_data_pin_o,
  output logic mgmt_data_pin_oe_o,
  output logic cfg_req_o,
  output logic cfg_we_o,
  output logic [15:0] cfg_addr_o,
  output logic [15:0] cfg_wdata_o,
  input wire logic [15:0] cfg_rdata_i,
  input wire logic cfg_ack_i
);
  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK, S_WAIT} scap_sst_type;

  // ---- link domain ----
  logic rst_m; // reset sync first stage
  logic lrst; // link domain reset
  logic [5:0] strap_m, strap_s; // strap sync
  logic [1:0] pin_m, pin_s, pin_q; // {clock, data} pin sync and history
  logic [1:0] ack_m; // answer toggle sync first two stages
  logic ack_s, ack_q;
  logic [1:0] mode; // captured strap mode
  logic [3:0] addr_lo; // captured address straps
  logic ee_mode, sm_mode;
  logic [6:0] own_addr;
  logic scl, sda, scl_q, sda_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic ack_edge;

  // slave engine state
  scap_sst_type st, next_st;
  logic [2:0] cnt, next_cnt; // bit counter
  logic [7:0] shreg, next_shreg; // rx and tx shifter
  logic [2:0] idx, next_idx; // bytes taken since start
  logic full, next_full; // byte waiting for decision
  logic rd, next_rd; // read transfer active
  logic cmd_ok, next_cmd_ok; // command byte seen
  logic tx_hi, next_tx_hi; // high byte being sent
  logic acked, next_acked; // host acked last byte
  logic sda_drv, next_sda_drv; // pull data low
  logic [7:0] b0, next_b0, b1, next_b1; // value bytes
  logic [15:0] reg_num, next_reg_num;
  scap_pkg::scap_seq_type seq, next_seq;

  // request side of the crossing
  logic req_tgl, next_req_tgl;
  logic busy, next_busy;
  logic req_we, next_req_we;
  logic [15:0] req_addr, next_req_addr;
  logic [15:0] req_wdata, next_req_wdata;
  logic [15:0] rd_data, next_rd_data;
  logic [15:0] tx_word;

  // pin drive registers
  logic clk_o, next_clk_o, clk_oe, next_clk_oe;
  logic dat_o, next_dat_o, dat_oe, next_dat_oe;

  // ---- reference domain ----
  logic [1:0] rq_m; // request toggle sync first two stages
  logic rq_s, rq_q;
  logic ack_tgl, next_ack_tgl;
  logic [15:0] xfer_rdata, next_xfer_rdata;
  logic next_cfg_req, next_cfg_we;
  logic [15:0] next_cfg_addr, next_cfg_wdata;

  scap_ee_if ee ();

  // synchronisers: first stages feed only the next stage
  always_ff @(posedge link_clk_i) begin
    rst_m <= srst_i;
    lrst <= rst_m;
    strap_m <= {iface_select_strap_hi_i, iface_select_strap_lo_i, addr_strap_i};
    strap_s <= strap_m;
    pin_m <= {mgmt_clock_pin_i, mgmt_data_pin_i};
    pin_s <= pin_m;
    pin_q <= pin_s;
    ack_m <= {ack_m[0], ack_tgl};
    ack_s <= ack_m[1];
    ack_q <= ack_s;
  end

  // straps followed during reset, frozen after release
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      mode <= strap_s[5:4];
      addr_lo <= strap_s[3:0];
    end
  end

  assign ee_mode = (mode == scap_pkg::MODE_EEPROM);
  assign sm_mode = (mode == scap_pkg::MODE_SMBUS);
  assign own_addr = {scap_pkg::ADDR_FIXED, addr_lo};
  assign scl = pin_s[1];
  assign sda = pin_s[0];
  assign scl_q = pin_q[1];
  assign sda_q = pin_q[0];
  // edges on the oversampled pins
  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_det = scl & scl_q & sda_q & ~sda;
  assign stop_det = scl & scl_q & ~sda_q & sda;
  assign ack_edge = ack_s ^ ack_q;
  // late read data answers the fill pattern
  assign tx_word = busy ? scap_pkg::RD_FILL : rd_data;

  assign ee.run = ee_mode & ~lrst;
  assign ee.sda_i = sda;
  assign ee.word_ready = ee_mode & ~busy;

  scap_ee_master #(
    .EE_BYTES(EE_BYTES),
    .HALF_CYC(EE_HALF_CYC)
  ) u_ee (
    .link_clk_i(link_clk_i),
    .rst_i(lrst),
    .ee(ee.master)
  );

  // slave engine, request issue and pin muxing
  always_comb begin
    next_st = st; next_cnt = cnt; next_shreg = shreg; next_idx = idx;
    next_full = full; next_rd = rd; next_cmd_ok = cmd_ok; next_tx_hi = tx_hi;
    next_acked = acked; next_sda_drv = sda_drv; next_b0 = b0; next_b1 = b1;
    next_reg_num = reg_num; next_seq = seq;
    next_req_tgl = req_tgl; next_busy = busy; next_req_we = req_we;
    next_req_addr = req_addr; next_req_wdata = req_wdata; next_rd_data = rd_data;
    // answer from the reference side ends the request
    if (ack_edge) begin
      next_busy = 1'b0;
      if (!req_we) next_rd_data = xfer_rdata;
    end
    // eeprom words go straight to config writes
    if (ee.word_valid && ee.word_ready) begin
      next_req_we = 1'b1;
      next_req_addr = ee.word_addr;
      next_req_wdata = ee.word;
      next_req_tgl = ~req_tgl;
      next_busy = 1'b1;
    end
    case (st)
      S_IDLE: next_st = S_IDLE; // ignore traffic until a start
      S_RX: begin
        if (scl_rise) begin
          next_shreg = {shreg[6:0], sda};
          next_cnt = cnt + 1'b1;
          if (cnt == 3'h7) next_full = 1'b1;
        end else if (scl_fall && full) begin
          next_full = 1'b0;
          next_cnt = 3'h0;
          next_st = S_WAIT; // nack unless taken below
          case (idx)
            3'h0: begin
              if (shreg[7:1] == own_addr) begin
                if (!shreg[0]) begin
                  next_st = S_ACK;
                end else if (cmd_ok && seq == scap_pkg::SEQ_DATA && !busy) begin
                  // fetch now so data is back before the ack ends
                  next_rd = 1'b1;
                  next_req_we = 1'b0;
                  next_req_addr = reg_num;
                  next_req_tgl = ~req_tgl;
                  next_busy = 1'b1;
                  next_st = S_ACK;
                end
              end
            end
            3'h1: if (shreg == scap_pkg::CMD_CFG) begin
              next_cmd_ok = 1'b1;
              next_st = S_ACK;
            end
            3'h2: begin
              next_b0 = shreg;
              next_st = S_ACK;
            end
            3'h3: begin
              next_b1 = shreg;
              next_st = S_ACK;
            end
            default: next_st = S_WAIT;
          endcase
          if (next_st == S_ACK) begin
            next_sda_drv = 1'b1;
            next_idx = idx + 1'b1;
          end
        end
      end
      S_ACK: if (scl_fall) begin
        next_sda_drv = 1'b0;
        next_st = S_RX;
        if (rd) begin
          next_st = S_TX;
          next_shreg = tx_word[7:0];
          next_sda_drv = ~tx_word[7];
          next_cnt = 3'h0;
          next_tx_hi = 1'b0;
        end
      end
      S_TX: if (scl_fall) begin
        if (cnt == 3'h7) begin
          next_sda_drv = 1'b0;
          next_st = S_MACK;
        end else begin
          next_cnt = cnt + 1'b1;
          next_sda_drv = ~shreg[6];
          next_shreg = {shreg[6:0], 1'b1};
        end
      end
      S_MACK: begin
        if (scl_rise) begin
          next_acked = ~sda;
        end else if (scl_fall) begin
          next_st = S_WAIT;
          if (acked && !tx_hi) begin
            next_tx_hi = 1'b1;
            next_shreg = tx_word[15:8];
            next_sda_drv = ~tx_word[15];
            next_cnt = 3'h0;
            next_st = S_TX;
          end
        end
      end
      S_WAIT: next_st = S_WAIT;
      default: next_st = S_IDLE;
    endcase
    // start or repeated start restarts the byte count
    if (start_det) begin
      next_st = S_RX;
      next_cnt = 3'h0;
      next_idx = 3'h0;
      next_full = 1'b0;
      next_sda_drv = 1'b0;
      next_rd = 1'b0;
      if (st == S_IDLE) next_cmd_ok = 1'b0; // only a repeated start keeps it
    end
    // stop commits a complete write transaction
    if (stop_det) begin
      next_st = S_IDLE;
      next_sda_drv = 1'b0;
      if (rd) begin
        next_seq = scap_pkg::SEQ_SETUP;
      end else if (idx == 3'h4) begin
        case (seq)
          scap_pkg::SEQ_SETUP: next_seq = scap_pkg::SEQ_REG;
          scap_pkg::SEQ_REG: begin
            next_reg_num = {b1, b0};
            next_seq = scap_pkg::SEQ_DATA;
          end
          default: begin
            // write dropped if a fetch is still open
            if (!busy) begin
              next_req_we = 1'b1;
              next_req_addr = reg_num;
              next_req_wdata = {b1, b0};
              next_req_tgl = ~req_tgl;
              next_busy = 1'b1;
            end
            next_seq = scap_pkg::SEQ_SETUP;
          end
        endcase
      end
    end
    if (!sm_mode) begin
      next_st = S_IDLE;
      next_sda_drv = 1'b0;
    end
    // pin drivers per mode
    next_clk_o = 1'b0;
    next_clk_oe = 1'b0;
    next_dat_o = 1'b0;
    next_dat_oe = sm_mode & sda_drv;
    if (ee_mode) begin
      next_clk_o = ee.scl;
      next_clk_oe = 1'b1;
      next_dat_o = ee.sda_o;
      next_dat_oe = ee.sda_oe;
    end
  end

  // link domain registers
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      st <= S_IDLE; cnt <= 3'h0; shreg <= 8'h00; idx <= 3'h0; full <= 1'b0;
      rd <= 1'b0; cmd_ok <= 1'b0; tx_hi <= 1'b0; acked <= 1'b0; sda_drv <= 1'b0;
      b0 <= 8'h00; b1 <= 8'h00; reg_num <= 16'h0000; seq <= scap_pkg::SEQ_SETUP;
      req_tgl <= 1'b0; busy <= 1'b0; req_we <= 1'b0; req_addr <= 16'h0000;
      req_wdata <= 16'h0000; rd_data <= 16'h0000;
      clk_o <= 1'b0; clk_oe <= 1'b0; dat_o <= 1'b0; dat_oe <= 1'b0;
    end else begin
      st <= next_st; cnt <= next_cnt; shreg <= next_shreg; idx <= next_idx;
      full <= next_full; rd <= next_rd; cmd_ok <= next_cmd_ok; tx_hi <= next_tx_hi;
      acked <= next_acked; sda_drv <= next_sda_drv; b0 <= next_b0; b1 <= next_b1;
      reg_num <= next_reg_num; seq <= next_seq;
      req_tgl <= next_req_tgl; busy <= next_busy; req_we <= next_req_we;
      req_addr <= next_req_addr; req_wdata <= next_req_wdata; rd_data <= next_rd_data;
      clk_o <= next_clk_o; clk_oe <= next_clk_oe; dat_o <= next_dat_o; dat_oe <= next_dat_oe;
    end
  end

  assign mgmt_clock_pin_o = clk_o;
  assign mgmt_clock_pin_oe_o = clk_oe;
  assign mgmt_data_pin_o = dat_o;
  assign mgmt_data_pin_oe_o = dat_oe;

  // request toggle sync into the reference domain
  always_ff @(posedge ref_clk_i) begin
    rq_m <= {rq_m[0], req_tgl};
    rq_s <= rq_m[1];
    rq_q <= rq_s;
  end

  // config port: request held until acked; link words stay still meanwhile
  always_comb begin
    next_cfg_req = cfg_req_o;
    next_cfg_we = cfg_we_o;
    next_cfg_addr = cfg_addr_o;
    next_cfg_wdata = cfg_wdata_o;
    next_ack_tgl = ack_tgl;
    next_xfer_rdata = xfer_rdata;
    if (rq_s ^ rq_q) begin
      next_cfg_req = 1'b1;
      next_cfg_we = req_we;
      next_cfg_addr = req_addr;
      next_cfg_wdata = req_wdata;
    end else if (cfg_req_o && cfg_ack_i) begin
      next_cfg_req = 1'b0;
      if (!cfg_we_o) next_xfer_rdata = cfg_rdata_i;
      next_ack_tgl = ~ack_tgl;
    end
  end

  // reference domain registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cfg_req_o <= 1'b0;
      cfg_we_o <= 1'b0;
      cfg_addr_o <= 16'h0000;
      cfg_wdata_o <= 16'h0000;
      ack_tgl <= 1'b0;
      xfer_rdata <= 16'h0000;
    end else begin
      cfg_req_o <= next_cfg_req;
      cfg_we_o <= next_cfg_we;
      cfg_addr_o <= next_cfg_addr;
      cfg_wdata_o <= next_cfg_wdata;
      ack_tgl <= next_ack_tgl;
      xfer_rdata <= next_xfer_rdata;
    end
  end
endmodule : scap_top

// File: test/scap_top_monitor.sv
`timescale 1ns/1ps
// pin and config port checks, top ports only
module scap_top_monitor (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic link_clk_i,
  input wire logic iface_select_strap_hi_i,
  input wire logic iface_select_strap_lo_i,
  input wire logic mgmt_clock_pin_i,
  input wire logic mgmt_clock_pin_o,
  input wire logic mgmt_clock_pin_oe_o,
  input wire logic mgmt_data_pin_o,
  input wire logic mgmt_data_pin_oe_o,
  input wire logic cfg_req_o,
  input wire logic cfg_we_o,
  input wire logic [15:0] cfg_addr_o,
  input wire logic [15:0] cfg_wdata_o,
  input wire logic cfg_ack_i
);
  // strap decode, straps only move under reset
  wire logic smb = !iface_select_strap_hi_i && iface_select_strap_lo_i;
  wire logic ee = !iface_select_strap_hi_i && !iface_select_strap_lo_i;
  // request waiting, request taken
  sequence s_wait;
    cfg_req_o && !cfg_ack_i;
  endsequence
  sequence s_taken;
    cfg_req_o && cfg_ack_i;
  endsequence
  a_smb_clk_in: assert property (@(posedge link_clk_i) disable iff (srst_i) smb |-> !mgmt_clock_pin_oe_o)
    else $error("clock pin driven in smbus mode");
  a_smb_open_drain: assert property (@(posedge link_clk_i) disable iff (srst_i) smb |-> !mgmt_data_pin_o)
    else $error("data pin driven high in smbus mode");
  // link logic leaves reset a few cycles late, so wait eight
  a_ee_clk_drive: assert property (@(posedge link_clk_i) disable iff (srst_i) ee [*8] |-> mgmt_clock_pin_oe_o)
    else $error("clock pin not driven in eeprom mode");
  a_idle_pins: assert property (@(posedge link_clk_i) disable iff (srst_i)
    !smb && !ee |-> !mgmt_clock_pin_oe_o && !mgmt_data_pin_oe_o)
    else $error("pins driven with idle strap code");
  a_data_clk_low: assert property (@(posedge link_clk_i) disable iff (srst_i)
    smb && $changed(mgmt_data_pin_oe_o) |-> !$past(mgmt_clock_pin_i, 3))
    else $error("data pin moved while clock high");
  a_req_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    s_wait |=> cfg_req_o && $stable(cfg_addr_o) && $stable(cfg_wdata_o) && $stable(cfg_we_o))
    else $error("request changed before answer");
  a_req_drop: assert property (@(posedge ref_clk_i) disable iff (srst_i) s_taken |=> !cfg_req_o [*4])
    else $error("request not dropped after answer");
  a_req_mode: assert property (@(posedge ref_clk_i) disable iff (srst_i) cfg_req_o |-> smb || ee)
    else $error("request with idle strap code");
endmodule : scap_top_monitor

bind scap_top scap_top_monitor mon (.*);

// File: test/scap_smb_host.sv
`timescale 1ns/1ps
// smbus host: makes the clock, data open drain
module scap_smb_host #(
  parameter int Q = 200
) (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // idle: both released high, clock stands still
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // one bit, data set with clock low, sampled high
  task automatic pulse(input logic d, output logic b);
    sda_o = d;
    #Q scl_o = 1'b1;
    #Q b = sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask : pulse
  // byte out msb first, n high = nack
  task automatic put(input logic [7:0] v, output logic n);
    logic b;
    for (int i = 7; i >= 0; i--) pulse(v[i], b);
    pulse(1'b1, n);
  endtask : put
  // byte in, then host ack or nack
  task automatic get(input logic n, output logic [7:0] v);
    logic b;
    for (int i = 7; i >= 0; i--) pulse(1'b1, v[i]);
    pulse(n, b); // ack slot kept apart from the data bits
  endtask : get
  // start, also used as repeated start
  task automatic start();
    sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
    #Q;
  endtask : start
  task automatic stop();
    sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask : stop
  // write transaction, two bytes low first
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w, output logic [3:0] n);
    start();
    put({a, 1'b0}, n[3]);
    put(c, n[2]);
    put(w[7:0], n[1]);
    put(w[15:8], n[0]);
    stop();
  endtask : wr
  // read: command, repeated start, read address
  task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic [2:0] n);
    logic [7:0] lo;
    logic [7:0] hi;
    start();
    put({a, 1'b0}, n[2]);
    put(scap_pkg::CMD_CFG, n[1]);
    start();
    put({a, 1'b1}, n[0]);
    get(1'b0, lo);
    get(1'b1, hi);
    stop();
    d = {hi, lo};
  endtask : rd
endmodule : scap_smb_host

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
  logic ref_clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic iface_select_strap_hi_i = 1'b0;
  logic iface_select_strap_lo_i = 1'b0;
  logic [3:0] addr_strap_i = 4'h0;
  logic cfg_ack_i = 1'b0;
  logic [15:0] cfg_rdata_i = 16'h0000;
  logic h_scl;
  logic h_sda;
  logic mgmt_clock_pin_o, mgmt_clock_pin_oe_o, mgmt_data_pin_o, mgmt_data_pin_oe_o;
  logic cfg_req_o, cfg_we_o;
  logic [15:0] cfg_addr_o, cfg_wdata_o;
  int fail_count = 0;
  int tests_run = 0;
  int seed = 38845;
  logic [15:0] mem [logic [15:0]]; // config space stand-in
  logic [32:0] seen [$]; // taken requests {we, addr, data}
  // wire levels: pull-up on data, clock from whoever drives
  wire logic scl_w = mgmt_clock_pin_oe_o ? mgmt_clock_pin_o : h_scl;
  wire logic sda_w = h_sda & (!mgmt_data_pin_oe_o | mgmt_data_pin_o);
  scap_top #(.EE_BYTES(4), .EE_HALF_CYC(4)) uut (.*, .mgmt_clock_pin_i(scl_w), .mgmt_data_pin_i(sda_w));
  scap_smb_host host (.sda_i(sda_w), .scl_o(h_scl), .sda_o(h_sda));
  always #2.5 ref_clk_i = ~ref_clk_i;
  // link clock offset so edges never meet
  initial begin
    #1.3;
    forever #24 link_clk_i = ~link_clk_i;
  end
  // config port answer after a random wait
  // ack lowered on the edge after it was taken, never twice in one step
  initial forever begin
    @(posedge ref_clk_i);
    #1;
    if (cfg_ack_i === 1'b1) cfg_ack_i = 1'b0;
    else if (cfg_req_o === 1'b1) begin
      repeat ({$random(seed)} % 3) @(posedge ref_clk_i);
      #1 cfg_ack_i = 1'b1;
      cfg_rdata_i = mem.exists(cfg_addr_o) ? mem[cfg_addr_o] : 16'hffff;
      seen.push_back({cfg_we_o, cfg_addr_o, cfg_wdata_o});
      if (cfg_we_o) mem[cfg_addr_o] = cfg_wdata_o;
    end
  end
  task automatic check(input string what, input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // reset with straps set, then settle the link side
  task automatic rst(input logic [1:0] m, input logic [3:0] a);
    @(posedge ref_clk_i);
    #1 srst_i = 1'b1;
    {iface_select_strap_hi_i, iface_select_strap_lo_i} = m;
    addr_strap_i = a;
    repeat (40) @(posedge ref_clk_i);
    #1 srst_i = 1'b0;
    repeat (12) @(posedge link_clk_i);
    @(posedge ref_clk_i);
    #1;
  endtask : rst
  // hang guard, about a tenth beyond the expected run
  initial begin
    #500_000;
    fail_count++;
    print_verdict();
  end
  initial begin
    logic [1:0] d;
    logic [3:0] n;
    logic [2:0] m;
    logic [6:0] sa;
    logic [15:0] r, w, v;
    logic [32:0] q;
    logic [15:0] exp_mem [logic [15:0]];
    rst(2'h2, 4'h0);
    repeat (400) @(posedge ref_clk_i);
    check("idle pins", {mgmt_clock_pin_oe_o, mgmt_data_pin_oe_o}, 2'h0);
    rst(2'h0, 4'h0);
    d = 2'h0;
    repeat (2000) begin
      @(posedge ref_clk_i);
      d |= {mgmt_clock_pin_oe_o & ~mgmt_clock_pin_o, mgmt_data_pin_oe_o};
    end
    check("eeprom clock", d[1], 1'b1);
    check("eeprom data", d[0], 1'b1);
    check("eeprom writes", seen.size(), 0);
    rst(2'h1, 4'($random(seed)));
    sa = {scap_pkg::ADDR_FIXED, addr_strap_i};
    for (int k = 0; k < 2; k++) begin
      r = 16'($random(seed));
      w = 16'($random(seed));
      exp_mem[r] = w;
      host.wr(sa, scap_pkg::CMD_CFG, 16'h0000, n);
      check("setup ack", n, 4'h0);
      host.wr(sa, scap_pkg::CMD_CFG, r, n);
      check("reg ack", n, 4'h0);
      host.wr(sa, scap_pkg::CMD_CFG, w, n);
      check("data ack", n, 4'h0);
      repeat (100) @(posedge ref_clk_i);
      check("write req", seen.pop_front(), {1'b1, r, w});
      host.wr(sa, scap_pkg::CMD_CFG, 16'h0000, n);
      host.wr(sa, scap_pkg::CMD_CFG, r, n);
      host.rd(sa, v, m);
      check("read ack", m, 3'h0);
      check("read data", v, exp_mem[r]);
      q = seen.pop_front();
      check("read req", q[32:16], {1'b0, r});
    end
    host.wr(sa ^ 7'h01, scap_pkg::CMD_CFG, w, n);
    check("foreign addr", n, 4'hf);
    host.wr(sa, 8'h09, w, n);
    check("bad command", n, 4'h7);
    repeat (100) @(posedge ref_clk_i);
    check("stray reqs", seen.size(), 0);
    print_verdict();
  end
endmodule : tb
